// >>> core/tmc_regs.vh
/*
  Register offsets, field positions and reset values for
  the 16-bit timer control and status block.
  Assumes an 8-bit register port on the CPU clock.
*/
// Functional notes
// - All timer events share one interrupt, gated by enables and the global mask
// - Capture enable passes either capture flag to the interrupt
// - Compare enable passes either compare flag to the interrupt
// - Overflow enable passes the overflow flag to the interrupt
// - Force bit two copies level two onto compare-2 pin when enabled
// - Force bit one copies level one onto compare-1 pin when enabled, outside the pulse modes
// - Level two drives pin two on match two, pin one in pulse modes
// - Capture-1 edge select: 0 falling, 1 rising
// - Level one drives pin one on match one when enabled
// - Pin enables only route outputs; compare logic always runs
// - Single pulse mode: capture-1 edge starts one pulse, length compare one
// - PWM mode: pulse length compare one, period compare two
// - Clock select: 00 div4, 01 div2, 10 div8, 11 external
// - Without external input, external setting stops the counter
// - Capture-2 edge select: 0 falling, 1 rising
// - External clock edge select: 0 falling, 1 rising
// - Capture flag 1 sets on edge or PWM period; two-step clear
// - Compare flags set on match; clear by status read then low byte access
// - Overflow sets on rollover; cleared via counter low, not alternate low
// - Capture flag 2 sets on edge; two-step clear via capture-2 low byte
// - Freeze bit stops prescaler and counter, disables compare outputs
// - Counter low byte write resets counter to FFFC
`ifndef TMC_REGS_VH
`define TMC_REGS_VH
`define TMC_CR2 4'h1
`define TMC_CR1 4'h2
`define TMC_CSR 4'h3
`define TMC_IC1H 4'h4
`define TMC_IC1L 4'h5
`define TMC_OC1H 4'h6
`define TMC_OC1L 4'h7
`define TMC_CNTH 4'h8
`define TMC_CNTL 4'h9
`define TMC_ACNTH 4'ha
`define TMC_ACNTL 4'hb
`define TMC_IC2H 4'hc
`define TMC_IC2L 4'hd
`define TMC_OC2H 4'he
`define TMC_OC2L 4'hf
`define TMC_CTRL_RESET 8'h00
`define TMC_CNT_RESET 16'hfffc
`define TMC_OC_RESET 16'h8000
// Control one fields
`define TMC_B_CIE 7
`define TMC_B_OIE 6
`define TMC_B_TIE 5
`define TMC_B_FL2 4
`define TMC_B_FL1 3
`define TMC_B_LV2 2
`define TMC_B_IE1 1
`define TMC_B_LV1 0
// Control two fields
`define TMC_B_PE1 7
`define TMC_B_PE2 6
`define TMC_B_OPM 5
`define TMC_B_PWM 4
`define TMC_B_CSH 3
`define TMC_B_CSL 2
`define TMC_B_IE2 1
`define TMC_B_EXE 0
// Status fields
`define TMC_B_CF1 7
`define TMC_B_MF1 6
`define TMC_B_OVF 5
`define TMC_B_CF2 4
`define TMC_B_MF2 3
`define TMC_B_FRZ 2
`endif

// >>> core/tmc_timer.v
/*
  16-bit free-running timer: control, status, flags, captures, compares,
  prescaler, single pulse and PWM waveform on compare-1 pin.
  Assumes all pin inputs are synchronous to clk and a one-cycle strobe bus.
*/
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "tmc_regs.vh"
module tmc_timer #(
  parameter HAS_EXT_CLOCK = 1
)(
  input wire clk,
  input wire rst_n,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  input wire global_irq_mask,
  input wire capture_one_pin,
  input wire capture_two_pin,
  input wire external_count_pin,
  output reg compare_one_pin,
  output wire compare_one_pin_oe,
  output reg compare_two_pin,
  output wire compare_two_pin_oe,
  output wire timer_irq
);
  // Block overview for the next engineer:
  // The register port is a plain strobe bus. A write lands on the edge at which
  // wr is high. A read answers on rdata in the following cycle only; in every
  // other cycle rdata rests at zero, so a stale value can never be mistaken for
  // a fresh answer.
  //
  // The counter is sixteen bits wide and free running. It restarts from its
  // reset value on a write to either counter low byte, on the end of a PWM
  // period, and on the trigger edge in single pulse mode.
  //
  // Counting is paced by one clock only. The prescaler is a free-running
  // three-bit count, and the selected rate becomes a one-cycle tick. The
  // prescaler phase is therefore not restarted by a clock select change;
  // software that needs an exact first interval must allow for that.
  //
  // Every flag is set by hardware and cleared by a two-step sequence: a status
  // read that saw the flag set arms the clear, and a later access to the
  // matching low byte completes it. An event in the completing cycle wins, so
  // an event is never lost to a clear that raced with it.
  //
  // In PWM mode both compare values are double-buffered. New values reach the
  // shadows only at the end of a period, and a written high byte holds the
  // transfer back until its low byte follows, so a half-written value never
  // shapes a pulse.
  //
  // Freeze stops the prescaler and the counter, parks both pins low and drops
  // both output enables. Registers stay reachable so that software can set up
  // the next run while nothing moves.
  //
  // The interrupt request is a plain level built from registered flags and
  // enables, gated by the global mask. It carries no edge memory of its own.
  //
  // HAS_EXT_CLOCK tells whether the external count pin exists. Without it the
  // external clock setting simply leaves the counter standing still.

  // ==========================================================
  // Registers
  reg [7:0] timer_control_one;
  reg [7:0] timer_control_two;
  reg capture_one_flag, compare_one_flag, overflow_flag, capture_two_flag, compare_two_flag;
  reg timer_freeze;
  reg [15:0] counter;
  reg [15:0] compare_value_one, compare_value_two;
  reg [15:0] shadow_one, shadow_two;
  reg lock_one, lock_two;
  reg [15:0] capture_one, capture_two;
  reg [2:0] prescale;
  reg cap1_d, cap2_d, ext_d;
  reg armed_cap1, armed_cmp1, armed_ovf, armed_cap2, armed_cmp2;
  reg pulse_active;
  reg [7:0] next_rdata;

  wire single_pulse_mode = timer_control_two[`TMC_B_OPM];
  wire pwm_mode = timer_control_two[`TMC_B_PWM];
  wire one_pulse = single_pulse_mode & ~pwm_mode;
  wire [1:0] clock_select = timer_control_two[`TMC_B_CSH:`TMC_B_CSL];
  wire out_level_one = timer_control_one[`TMC_B_LV1];
  wire out_level_two = timer_control_one[`TMC_B_LV2];
  wire compare_one_pin_en = timer_control_two[`TMC_B_PE1];
  wire compare_two_pin_en = timer_control_two[`TMC_B_PE2];

  // Selected edge on a sampled input; sel 1 means rising
  function edge_seen;
    input now;
    input was;
    input sel;
    begin
      edge_seen = sel ? (now & ~was) : (~now & was);
    end
  endfunction

  // ==========================================================
  // Prescaler and tick generation
  wire cap1_edge = edge_seen(capture_one_pin, cap1_d, timer_control_one[`TMC_B_IE1]);
  wire cap2_edge = edge_seen(capture_two_pin, cap2_d, timer_control_two[`TMC_B_IE2]);
  wire ext_edge = edge_seen(external_count_pin, ext_d, timer_control_two[`TMC_B_EXE]);
  reg tick;
  always @*
  begin
    case (clock_select)
      2'b00: tick = (prescale[1:0] == 2'b11);
      2'b01: tick = prescale[0];
      2'b10: tick = (prescale == 3'b111);
      default: tick = (HAS_EXT_CLOCK != 0) & ext_edge;
    endcase
    tick = tick & ~timer_freeze;
  end

  wire bus_low_hit_cntl = (rd | wr) & (addr == `TMC_CNTL);
  wire cnt_reset = (wr & ((addr == `TMC_CNTL) | (addr == `TMC_ACNTL)))
                   | (tick & pwm_mode & (counter == shadow_two)) // PWM period end
                   | (one_pulse & cap1_edge);
  wire [15:0] cmp1 = pwm_mode ? shadow_one : compare_value_one;
  wire [15:0] cmp2 = pwm_mode ? shadow_two : compare_value_two;
  // Match events fire on the tick taken while the counter holds the value
  wire match_one = tick & (counter == cmp1);
  wire match_two = tick & (counter == cmp2);
  wire roll = tick & (counter == 16'hffff);

  // Events per flag; capture-1 edges and compare-1 events are inhibited in both pulse modes (PWM period end sets capture-1), compare-2 only in PWM, capture-2 never
  wire ev_cap1 = (cap1_edge & ~pwm_mode & ~one_pulse) | (match_two & pwm_mode);
  wire ev_cmp1 = match_one & ~pwm_mode & ~one_pulse;
  wire ev_cmp2 = match_two & ~pwm_mode;
  wire ev_cap2 = cap2_edge;

  // ==========================================================
  // Two-step clear qualifiers
  wire csr_read = rd & (addr == `TMC_CSR);
  wire acc_ic1l = (rd | wr) & (addr == `TMC_IC1L);
  wire acc_ic2l = (rd | wr) & (addr == `TMC_IC2L);
  wire acc_oc1l = (rd | wr) & (addr == `TMC_OC1L);
  wire acc_oc2l = (rd | wr) & (addr == `TMC_OC2L);

  // Counter, prescaler, input history
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      counter <= `TMC_CNT_RESET;
      prescale <= 3'b000;
      cap1_d <= 1'b0;
      cap2_d <= 1'b0;
      ext_d <= 1'b0;
    end
    else
    begin
      cap1_d <= capture_one_pin;
      cap2_d <= capture_two_pin;
      ext_d <= external_count_pin;
      if (!timer_freeze)
        prescale <= prescale + 3'b001;
      if (cnt_reset)
        counter <= `TMC_CNT_RESET;
      else if (tick)
        counter <= counter + 16'h0001;
    end
  end

  // ==========================================================
  // Flags: set wins over the clear so no event is lost
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      capture_one_flag <= 1'b0;
      compare_one_flag <= 1'b0;
      overflow_flag <= 1'b0;
      capture_two_flag <= 1'b0;
      compare_two_flag <= 1'b0;
      armed_cap1 <= 1'b0;
      armed_cmp1 <= 1'b0;
      armed_ovf <= 1'b0;
      armed_cap2 <= 1'b0;
      armed_cmp2 <= 1'b0;
      timer_freeze <= 1'b0;
    end
    else
    begin
      if (wr && addr == `TMC_CSR)
        timer_freeze <= wdata[`TMC_B_FRZ];
      // Arm on a status read that saw the flag set
      if (csr_read)
      begin
        armed_cap1 <= capture_one_flag;
        armed_cmp1 <= compare_one_flag;
        armed_ovf <= overflow_flag;
        armed_cap2 <= capture_two_flag;
        armed_cmp2 <= compare_two_flag;
      end
      if (ev_cap1)
        capture_one_flag <= 1'b1;
      else if (armed_cap1 && acc_ic1l)
      begin
        capture_one_flag <= 1'b0;
        armed_cap1 <= 1'b0;
      end
      if (ev_cmp1)
        compare_one_flag <= 1'b1;
      else if (armed_cmp1 && acc_oc1l)
      begin
        compare_one_flag <= 1'b0;
        armed_cmp1 <= 1'b0;
      end
      if (roll)
        overflow_flag <= 1'b1;
      else if (armed_ovf && bus_low_hit_cntl)
      begin
        overflow_flag <= 1'b0;
        armed_ovf <= 1'b0;
      end
      if (ev_cap2)
        capture_two_flag <= 1'b1;
      else if (armed_cap2 && acc_ic2l)
      begin
        capture_two_flag <= 1'b0;
        armed_cap2 <= 1'b0;
      end
      if (ev_cmp2)
        compare_two_flag <= 1'b1;
      else if (armed_cmp2 && acc_oc2l)
      begin
        compare_two_flag <= 1'b0;
        armed_cmp2 <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Control and data registers; compare values double-buffered for PWM
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer_control_one <= `TMC_CTRL_RESET;
      timer_control_two <= `TMC_CTRL_RESET;
      compare_value_one <= `TMC_OC_RESET;
      compare_value_two <= `TMC_OC_RESET;
      shadow_one <= `TMC_OC_RESET;
      shadow_two <= `TMC_OC_RESET;
      lock_one <= 1'b0;
      lock_two <= 1'b0;
      capture_one <= 16'h0000;
      capture_two <= 16'h0000;
    end
    else
    begin
      if (wr)
      begin
        case (addr)
          `TMC_CR1: timer_control_one <= wdata;
          `TMC_CR2: timer_control_two <= wdata;
          `TMC_OC1H: compare_value_one[15:8] <= wdata;
          `TMC_OC1L: compare_value_one[7:0] <= wdata;
          `TMC_OC2H: compare_value_two[15:8] <= wdata;
          `TMC_OC2L: compare_value_two[7:0] <= wdata;
          default: ;
        endcase
      end
      // High byte write locks transfer until the low byte follows
      if (wr && addr == `TMC_OC1H)
        lock_one <= 1'b1;
      else if (wr && addr == `TMC_OC1L)
        lock_one <= 1'b0;
      if (wr && addr == `TMC_OC2H)
        lock_two <= 1'b1;
      else if (wr && addr == `TMC_OC2L)
        lock_two <= 1'b0;
      if (!pwm_mode || (match_two && !lock_one))
        shadow_one <= compare_value_one;
      if (!pwm_mode || (match_two && !lock_two))
        shadow_two <= compare_value_two;
      if (cap1_edge && !pwm_mode && !one_pulse)
        capture_one <= counter;
      if (cap2_edge)
        capture_two <= counter;
    end
  end

  // ==========================================================
  // Compare pin levels; freeze parks both pins low
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      compare_one_pin <= 1'b0;
      compare_two_pin <= 1'b0;
      pulse_active <= 1'b0;
    end
    else if (timer_freeze)
    begin
      compare_one_pin <= 1'b0;
      compare_two_pin <= 1'b0;
      pulse_active <= 1'b0;
    end
    else
    begin
      if (pwm_mode)
      begin
        // Period restart drives level two, pulse end drives level one
        if (match_two)
          compare_one_pin <= out_level_two;
        else if (match_one)
          compare_one_pin <= out_level_one;
      end
      else if (one_pulse)
      begin
        if (cap1_edge)
        begin
          compare_one_pin <= out_level_two;
          pulse_active <= 1'b1;
        end
        else if (pulse_active && match_one)
        begin
          compare_one_pin <= out_level_one;
          pulse_active <= 1'b0;
        end
      end
      else if (timer_control_one[`TMC_B_FL1] || match_one)
        compare_one_pin <= out_level_one;
      if (timer_control_one[`TMC_B_FL2] || (match_two && !one_pulse && !pwm_mode))
        compare_two_pin <= out_level_two;
    end
  end

  // Pin enables only route; compare logic above ignores them
  assign compare_one_pin_oe = compare_one_pin_en & ~timer_freeze;
  assign compare_two_pin_oe = compare_two_pin_en & ~timer_freeze;

  // Shared request line
  assign timer_irq = ~global_irq_mask & (
    (timer_control_one[`TMC_B_CIE] & (capture_one_flag | capture_two_flag))
    | (timer_control_one[`TMC_B_OIE] & (compare_one_flag | compare_two_flag))
    | (timer_control_one[`TMC_B_TIE] & overflow_flag));

  // ==========================================================
  // Read mux, answered one cycle after the strobe
  always @*
  begin
    case (addr)
      `TMC_CR1: next_rdata = timer_control_one;
      `TMC_CR2: next_rdata = timer_control_two;
      `TMC_CSR: next_rdata = {capture_one_flag, compare_one_flag, overflow_flag,
                              capture_two_flag, compare_two_flag, timer_freeze, 2'b00};
      `TMC_IC1H: next_rdata = capture_one[15:8];
      `TMC_IC1L: next_rdata = capture_one[7:0];
      `TMC_OC1H: next_rdata = compare_value_one[15:8];
      `TMC_OC1L: next_rdata = compare_value_one[7:0];
      `TMC_OC2H: next_rdata = compare_value_two[15:8];
      `TMC_OC2L: next_rdata = compare_value_two[7:0];
      `TMC_CNTH: next_rdata = counter[15:8];
      `TMC_CNTL: next_rdata = counter[7:0];
      `TMC_ACNTH: next_rdata = counter[15:8];
      `TMC_ACNTL: next_rdata = counter[7:0];
      `TMC_IC2H: next_rdata = capture_two[15:8];
      `TMC_IC2L: next_rdata = capture_two[7:0];
      default: next_rdata = 8'h00;
    endcase
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 8'h00;
    else if (rd)
      rdata <= next_rdata;
    else
      rdata <= 8'h00;
  end
endmodule

// >>> test/tmc_timer_asserts.sv
/*
  Port checker for tmc_timer: pin enables, forced levels, freeze, irq gating.
  Assumes the one-cycle strobe register port and rdata one cycle after rd.
*/
`timescale 1ns/1ps
`include "tmc_regs.vh"
module tmc_timer_asserts (
  input wire clk,
  input wire rst_n,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  input wire global_irq_mask,
  input wire compare_one_pin,
  input wire compare_one_pin_oe,
  input wire compare_two_pin,
  input wire compare_two_pin_oe,
  input wire timer_irq
);
  // ==========================================
  // Shadow of control bits, seen from the port
  reg [7:0] c1;
  reg [7:0] c2;
  reg frz;
  // Mirrors the writes so pins can be tied to their causes
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      c1 <= 8'h00;
      c2 <= 8'h00;
      frz <= 1'b0;
    end
    else if (wr)
    begin
      if (addr == `TMC_CR1) c1 <= wdata;
      if (addr == `TMC_CR2) c2 <= wdata;
      if (addr == `TMC_CSR) frz <= wdata[2];
    end
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_stat_rd;
    rd && addr == `TMC_CSR;
  endsequence
  // Pulse modes steer level two onto pin one, so force is checked outside them
  sequence s_force_one;
    c1[3] && c2[7] && !frz && c2[5:4] == 2'b00;
  endsequence
  sequence s_force_two;
    c1[4] && c2[6] && !frz && c2[5:4] == 2'b00;
  endsequence
  a_irq_masked: assert property (global_irq_mask |-> !timer_irq)
    else $error("irq raised while masked");
  a_irq_no_enable: assert property (c1[7:5] == 3'b000 |-> !timer_irq)
    else $error("irq raised with all enables off");
  a_oe_one_route: assert property (compare_one_pin_oe == (c2[7] && !frz))
    else $error("pin one enable wrong");
  a_oe_two_route: assert property (compare_two_pin_oe == (c2[6] && !frz))
    else $error("pin two enable wrong");
  a_freeze_pins: assert property (frz && $past(frz) |-> !compare_one_pin && !compare_two_pin)
    else $error("pins driven while frozen");
  a_force_one: assert property (s_force_one |=> compare_one_pin == $past(c1[0]))
    else $error("forced level one missing");
  a_force_two: assert property (s_force_two |=> compare_two_pin == $past(c1[2]))
    else $error("forced level two missing");
  a_status_low_zero: assert property (s_stat_rd |=> rdata[1:0] == 2'b00)
    else $error("status low bits not zero");
  a_status_freeze_bit: assert property (s_stat_rd |=> rdata[2] == $past(frz))
    else $error("freeze bit read back wrong");
endmodule
bind tmc_timer tmc_timer_asserts u_chk (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .global_irq_mask(global_irq_mask), .compare_one_pin(compare_one_pin),
  .compare_one_pin_oe(compare_one_pin_oe), .compare_two_pin(compare_two_pin),
  .compare_two_pin_oe(compare_two_pin_oe), .timer_irq(timer_irq));

// >>> test/tmc_timer_tb.sv
/*
  Self-checking bench for tmc_timer: register tasks and directed tests.
  Assumes the 4-bit register map of tmc_regs.vh and synchronous pin inputs.
*/
`timescale 1ns/1ps
`include "tmc_regs.vh"
module tmc_timer_tb;
  // ==========================================
  // Signals and tasks
  reg clk;
  reg rst_n;
  reg [3:0] addr;
  reg [7:0] wdata;
  reg wr;
  reg rd;
  reg global_irq_mask;
  reg capture_one_pin;
  reg capture_two_pin;
  reg external_count_pin;
  wire [7:0] rdata;
  wire p1;
  wire oe1;
  wire p2;
  wire oe2;
  wire timer_irq;
  integer miscompares;
  integer compares;
  integer i;
  reg [7:0] a;
  reg [7:0] b;
  reg [7:0] v;
  tmc_timer #(.HAS_EXT_CLOCK(1)) dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .global_irq_mask(global_irq_mask), .capture_one_pin(capture_one_pin),
    .capture_two_pin(capture_two_pin), .external_count_pin(external_count_pin), .compare_one_pin(p1),
    .compare_one_pin_oe(oe1), .compare_two_pin(p2), .compare_two_pin_oe(oe2), .timer_irq(timer_irq));
  // Free-running 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task stop_test;
  begin
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
  begin
    compares = compares + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task bw(input [3:0] ad, input [7:0] d);
  begin
    @(posedge clk);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  end
  endtask
  // Read data stand only in the cycle after the strobe
  task br(input [3:0] ad, output [7:0] d);
  begin
    @(posedge clk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  end
  endtask
  task rm(input [3:0] ad, input [7:0] m, input [7:0] e);
  begin
    br(ad, v);
    chk(v & m, e);
  end
  endtask
  // Polls status; the read also arms the two-step clear
  task wait_st(input [7:0] m);
  begin
    i = 0;
    br(`TMC_CSR, v);
    while ((v & m) == 8'h00 && i < 300)
    begin
      br(`TMC_CSR, v);
      i = i + 1;
    end
    if (i == 300)
    begin
      miscompares = miscompares + 1;
      stop_test;
    end
  end
  endtask
  // ==========================================
  // Test sequence
  initial
  begin
    {rst_n, addr, wdata, wr, rd, global_irq_mask, capture_two_pin, external_count_pin} = 0;
    capture_one_pin = 1'b1;
    miscompares = 0;
    compares = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rm(`TMC_CR1, 8'hff, 8'h00);
    rm(`TMC_CR2, 8'hff, 8'h00);
    rm(`TMC_CSR, 8'hff, 8'h00);
    rm(`TMC_CNTH, 8'hff, 8'hff);
    $display("reset test done");
    // Prescaler phase is free-running, so 32 cycles give an exact tick count
    for (i = 0; i < 3; i = i + 1)
    begin
      bw(`TMC_CR2, {4'h0, i[1:0], 2'b00});
      br(`TMC_CNTL, a);
      repeat (30) @(posedge clk);
      br(`TMC_CNTL, b);
      chk(b - a, (i == 0) ? 8'h08 : (i == 1) ? 8'h10 : 8'h04);
    end
    // Nine toggles give five edges of the selected kind, four of the other
    for (i = 0; i < 2; i = i + 1)
    begin
      bw(`TMC_CR2, 8'h0d - i[7:0]);
      br(`TMC_CNTL, a);
      repeat (9)
      begin
        @(posedge clk);
        external_count_pin <= ~external_count_pin;
        @(posedge clk);
      end
      repeat (3) @(posedge clk);
      br(`TMC_CNTL, b);
      chk(b - a, 8'h05);
    end
    $display("clock test done");
    bw(`TMC_CR2, 8'h04);
    bw(`TMC_CNTL, 8'h00);
    rm(`TMC_CNTH, 8'hff, 8'hff);
    wait_st(8'h20);
    bw(`TMC_CR1, 8'h20);
    chk({7'h00, timer_irq}, 8'h01);
    @(posedge clk);
    global_irq_mask <= 1'b1;
    #1;
    chk({7'h00, timer_irq}, 8'h00);
    @(posedge clk);
    global_irq_mask <= 1'b0;
    br(`TMC_ACNTL, v);
    rm(`TMC_CSR, 8'hff, 8'h20);
    br(`TMC_CNTL, v);
    rm(`TMC_CSR, 8'hff, 8'h00);
    $display("overflow test done");
    bw(`TMC_OC1H, 8'hff);
    bw(`TMC_OC1L, 8'hfe);
    bw(`TMC_OC2H, 8'hff);
    bw(`TMC_OC2L, 8'hff);
    bw(`TMC_CR2, 8'hc4);
    bw(`TMC_CR1, 8'h45);
    bw(`TMC_CNTL, 8'h00);
    wait_st(8'h08);
    chk(v, 8'h68);
    chk({4'h0, oe2, oe1, p2, p1}, 8'h0f);
    chk({7'h00, timer_irq}, 8'h01);
    bw(`TMC_OC1L, 8'hfe);
    rm(`TMC_CSR, 8'h48, 8'h08);
    // Force pulls both pins back to the cleared levels
    bw(`TMC_CR1, 8'h18);
    @(posedge clk);
    #1;
    chk({4'h0, oe2, oe1, p2, p1}, 8'h0c);
    $display("compare test done");
    bw(`TMC_CSR, 8'h04);
    @(posedge clk);
    #1;
    chk({4'h0, oe2, oe1, p2, p1}, 8'h00);
    br(`TMC_CNTL, a);
    repeat (16) @(posedge clk);
    br(`TMC_CNTL, b);
    chk(b, a);
    rm(`TMC_CSR, 8'h07, 8'h04);
    bw(`TMC_CSR, 8'h00);
    $display("freeze test done");
    bw(`TMC_CR1, 8'h82);
    @(posedge clk);
    capture_one_pin <= 1'b0;
    capture_two_pin <= 1'b1;
    repeat (3) @(posedge clk);
    rm(`TMC_CSR, 8'h90, 8'h00);
    @(posedge clk);
    capture_one_pin <= 1'b1;
    capture_two_pin <= 1'b0;
    repeat (3) @(posedge clk);
    rm(`TMC_CSR, 8'h90, 8'h90);
    chk({7'h00, timer_irq}, 8'h01);
    br(`TMC_IC1L, v);
    rm(`TMC_CSR, 8'h90, 8'h10);
    br(`TMC_IC2L, v);
    rm(`TMC_CSR, 8'h90, 8'h00);
    chk({7'h00, timer_irq}, 8'h00);
    $display("capture test done");
    // PWM: level two at period start, level one at match one, period ends on compare two
    bw(`TMC_CR1, 8'h04);
    bw(`TMC_OC1L, 8'h08);
    bw(`TMC_OC1H, 8'h00);
    bw(`TMC_OC2L, 8'h20);
    bw(`TMC_OC2H, 8'h00);
    bw(`TMC_CR2, 8'h94);
    bw(`TMC_CNTL, 8'h00);
    wait_st(8'h80);
    chk({6'h00, oe1, p1}, 8'h03);
    repeat (30) @(posedge clk);
    #1;
    chk({6'h00, oe1, p1}, 8'h02);
    rm(`TMC_CSR, 8'h40, 8'h00);
    $display("pwm test done");
    stop_test;
  end
endmodule
